// *** logic/mbo_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "mbo_defs.svh"
module mbo_top
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // skip strobe toward sequencer
  output logic             skip_next_r
);
  mbo_pkg::mbo_state_t st_r;
  logic [3:0]  op_r;
  logic        dest_r;
  logic [7:0]  lit_r;
  logic [6:0]  adr_r;
  logic [2:0]  bsel_r;
  logic [7:0]  acc_r;
  logic        c_r;
  logic        dc_r;
  logic        z_r;
  logic        skipped_r;
  logic [7:0]  rdat;
  logic [7:0]  res;
  logic        c_n;
  logic        dc_n;
  logic        z_n;
  logic        bit_v;
  logic        aw_ok_r;
  logic        w_ok_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic        wr_fire;
  logic        go;
  logic        rf_we;
  logic        rf_sw_we;
  logic        is_reg_op;
  logic        is_imm_op;
  logic        is_add;
  logic        to_acc;
  logic [6:0]  rf_rd_addr;

  // operand read port of register file
  assign rf_rd_addr = (st_r == mbo_pkg::MBO_ST_IDLE && rf_sw_we) ? adr_r : adr_r;

  mbo_rfile u_rfile
  (
    .core_clk (core_clk),
    .wr_en    (rf_we),
    .wr_addr  (adr_r),
    .wr_data  (rf_sw_we ? wdata_r[7:0] : res),
    .rd_addr  (rf_rd_addr),
    .rd_data  (rdat)
  );

  mbo_alu u_alu
  (
    .op      (op_r),
    .acc     (acc_r),
    .lit     (lit_r),
    .rdat    (rdat),
    .bsel    (bsel_r),
    .res     (res),
    .c_out   (c_n),
    .dc_out  (dc_n),
    .z_out   (z_n),
    .bit_val (bit_v)
  );

  // operation classes
  always_comb
  begin
    is_imm_op = (op_r == mbo_pkg::MBO_OP_ADD_IMM) || (op_r == mbo_pkg::MBO_OP_AND_IMM) ||
                (op_r == mbo_pkg::MBO_OP_XOR_IMM);
    is_reg_op = (op_r == mbo_pkg::MBO_OP_ADD_REG) || (op_r == mbo_pkg::MBO_OP_AND_REG) ||
                (op_r == mbo_pkg::MBO_OP_XOR_REG);
    is_add = (op_r == mbo_pkg::MBO_OP_ADD_IMM) || (op_r == mbo_pkg::MBO_OP_ADD_REG);
    to_acc = is_imm_op || (is_reg_op && !dest_r);
  end

  // write handshake and decode
  assign wr_fire = aw_ok_r && w_ok_r && !s_axi_bvalid;
  assign go = wr_fire && (awaddr_r == `MBO_ADDR_CTRL) && wdata_r[`MBO_CTRL_GO] &&
              (st_r == mbo_pkg::MBO_ST_IDLE);
  assign rf_sw_we = wr_fire && (awaddr_r == `MBO_ADDR_RFILE) && s_wstrb0_r;
  assign rf_we = rf_sw_we || (st_r == mbo_pkg::MBO_ST_EXEC &&
                 ((is_reg_op && dest_r) || op_r == mbo_pkg::MBO_OP_BIT_CLR ||
                  op_r == mbo_pkg::MBO_OP_BIT_SET));

  logic s_wstrb0_r;

  // sequencer: read, execute, optional skip slot
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      st_r <= mbo_pkg::MBO_ST_IDLE;
    end
    else
    begin
      case (st_r)
        mbo_pkg::MBO_ST_IDLE: if (go) st_r <= mbo_pkg::MBO_ST_READ;
        mbo_pkg::MBO_ST_READ: st_r <= mbo_pkg::MBO_ST_EXEC;
        mbo_pkg::MBO_ST_EXEC:
          if (op_r == mbo_pkg::MBO_OP_TEST_SKIP && bit_v)
            st_r <= mbo_pkg::MBO_ST_SKIP;
          else
            st_r <= mbo_pkg::MBO_ST_IDLE;
        mbo_pkg::MBO_ST_SKIP: st_r <= mbo_pkg::MBO_ST_IDLE;
        default: st_r <= mbo_pkg::MBO_ST_IDLE;
      endcase
    end
  end

  // accumulator and flags
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      acc_r <= `MBO_ZERO8;
      c_r <= 1'b0;
      dc_r <= 1'b0;
      z_r <= 1'b0;
    end
    else if (st_r == mbo_pkg::MBO_ST_EXEC && (is_imm_op || is_reg_op))
    begin
      if (to_acc)
        acc_r <= res;
      z_r <= z_n;
      if (is_add)
      begin
        c_r <= c_n;
        dc_r <= dc_n;
      end
    end
    else if (wr_fire && awaddr_r == `MBO_ADDR_ACC && s_wstrb0_r)
    begin
      acc_r <= wdata_r[7:0];
    end
  end

  // skip strobe and skip record, rewritten by every test-skip op
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      skip_next_r <= 1'b0;
      skipped_r <= 1'b0;
    end
    else
    begin
      skip_next_r <= (st_r == mbo_pkg::MBO_ST_EXEC) && (op_r == mbo_pkg::MBO_OP_TEST_SKIP) &&
                     bit_v;
      if (st_r == mbo_pkg::MBO_ST_EXEC && op_r == mbo_pkg::MBO_OP_TEST_SKIP)
        skipped_r <= bit_v;
    end
  end

  // command and operand latches
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      op_r <= 4'h0;
      dest_r <= 1'b0;
      lit_r <= `MBO_ZERO8;
      adr_r <= 7'h00;
      bsel_r <= 3'h0;
    end
    else if (wr_fire && st_r == mbo_pkg::MBO_ST_IDLE)
    begin
      if (awaddr_r == `MBO_ADDR_CTRL)
      begin
        op_r <= wdata_r[`MBO_CTRL_OP_HI:`MBO_CTRL_OP_LO];
        dest_r <= wdata_r[`MBO_CTRL_DEST];
      end
      if (awaddr_r == `MBO_ADDR_OPND)
      begin
        lit_r <= wdata_r[`MBO_OPND_LIT_HI:`MBO_OPND_LIT_LO];
        adr_r <= wdata_r[`MBO_OPND_ADR_HI:`MBO_OPND_ADR_LO];
        bsel_r <= wdata_r[`MBO_OPND_BIT_HI:`MBO_OPND_BIT_LO];
      end
    end
  end

  // axi write channels, address and data in either order
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      s_wstrb0_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MBO_AXI_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_ok_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_ok_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ok_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ok_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        s_wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r > `MBO_ADDR_RFILE || awaddr_r[1:0] != 2'b00) ?
                       `MBO_AXI_SLVERR : `MBO_AXI_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // axi read channel
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MBO_AXI_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `MBO_AXI_OKAY;
        case (s_axi_araddr)
          `MBO_ADDR_CTRL: s_axi_rdata <= {24'h0, op_r, 2'b00, dest_r, 1'b0};
          `MBO_ADDR_OPND: s_axi_rdata <= {13'h0, bsel_r, 1'b0, adr_r, lit_r};
          `MBO_ADDR_ACC: s_axi_rdata <= {24'h0, acc_r};
          `MBO_ADDR_FLAGS: s_axi_rdata <= {27'h0, (st_r != mbo_pkg::MBO_ST_IDLE),
                                           skipped_r, z_r, dc_r, c_r};
          `MBO_ADDR_RDATA: s_axi_rdata <= {24'h0, rdat};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MBO_AXI_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // assertions
  property p_logic_keeps_carry;
    @(posedge core_clk) disable iff (!nrst)
    (st_r == mbo_pkg::MBO_ST_EXEC && !is_add) |=> (c_r == $past(c_r) && dc_r == $past(dc_r));
  endproperty
  a_logic_keeps_carry: assert property (p_logic_keeps_carry) else $error("carry changed");

  property p_bit_ops_keep_flags;
    @(posedge core_clk) disable iff (!nrst)
    (st_r == mbo_pkg::MBO_ST_EXEC && !is_imm_op && !is_reg_op) |=> $stable({c_r, dc_r, z_r});
  endproperty
  a_bit_ops_keep_flags: assert property (p_bit_ops_keep_flags) else $error("flags moved");

  property p_skip_two_cycles;
    @(posedge core_clk) disable iff (!nrst)
    (st_r == mbo_pkg::MBO_ST_EXEC && op_r == mbo_pkg::MBO_OP_TEST_SKIP && bit_v)
      |=> skip_next_r && st_r == mbo_pkg::MBO_ST_SKIP ##1 st_r == mbo_pkg::MBO_ST_IDLE;
  endproperty
  a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip slot wrong");

  property p_no_skip_zero;
    @(posedge core_clk) disable iff (!nrst)
    (st_r == mbo_pkg::MBO_ST_EXEC && !bit_v) |=> !skip_next_r && st_r == mbo_pkg::MBO_ST_IDLE;
  endproperty
  a_no_skip_zero: assert property (p_no_skip_zero) else $error("false skip");

  property p_zero_flag;
    @(posedge core_clk) disable iff (!nrst)
    (st_r == mbo_pkg::MBO_ST_EXEC && (is_imm_op || is_reg_op)) |=> z_r == ($past(res) == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_acc_dest;
    @(posedge core_clk) disable iff (!nrst)
    (st_r == mbo_pkg::MBO_ST_EXEC && is_reg_op && dest_r) |=> $stable(acc_r);
  endproperty
  a_acc_dest: assert property (p_acc_dest) else $error("acc written for dest 1");

  property p_imm_to_acc;
    @(posedge core_clk) disable iff (!nrst)
    (st_r == mbo_pkg::MBO_ST_EXEC && is_imm_op) |=> acc_r == $past(res);
  endproperty
  a_imm_to_acc: assert property (p_imm_to_acc) else $error("acc not updated");

  property p_one_cycle;
    @(posedge core_clk) disable iff (!nrst)
    (st_r == mbo_pkg::MBO_ST_READ) |=> st_r == mbo_pkg::MBO_ST_EXEC
      ##1 (st_r == mbo_pkg::MBO_ST_IDLE || st_r == mbo_pkg::MBO_ST_SKIP);
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("exec overran");
endmodule
`default_nettype wire

// *** logic/mbo_defs.svh ***
`ifndef MBO_DEFS_SVH
`define MBO_DEFS_SVH
// register map, byte addresses
`define MBO_ADDR_CTRL    8'h00
`define MBO_ADDR_OPND    8'h04
`define MBO_ADDR_ACC     8'h08
`define MBO_ADDR_FLAGS   8'h0c
`define MBO_ADDR_RFILE   8'h10
`define MBO_ADDR_RDATA   8'h14
// ctrl fields
`define MBO_CTRL_GO      0
`define MBO_CTRL_DEST    1
`define MBO_CTRL_OP_LO   4
`define MBO_CTRL_OP_HI   7
// operand fields
`define MBO_OPND_LIT_LO  0
`define MBO_OPND_LIT_HI  7
`define MBO_OPND_ADR_LO  8
`define MBO_OPND_ADR_HI  14
`define MBO_OPND_BIT_LO  16
`define MBO_OPND_BIT_HI  18
// flags fields
`define MBO_FLG_C        0
`define MBO_FLG_DC       1
`define MBO_FLG_Z        2
`define MBO_FLG_SKIP     3
`define MBO_FLG_BUSY     4
// misc
`define MBO_RF_DEPTH     128
`define MBO_ZERO8        8'h00
`define MBO_AXI_OKAY     2'b00
`define MBO_AXI_SLVERR   2'b10
`endif

// *** logic/mbo_pkg.sv ***
package mbo_pkg;
  // operation codes written into ctrl
  typedef enum logic [3:0] {
    MBO_OP_NONE = 4'h0,
    MBO_OP_ADD_IMM = 4'h1,
    MBO_OP_ADD_REG = 4'h2,
    MBO_OP_AND_IMM = 4'h3,
    MBO_OP_AND_REG = 4'h4,
    MBO_OP_XOR_IMM = 4'h5,
    MBO_OP_XOR_REG = 4'h6,
    MBO_OP_BIT_CLR = 4'h7,
    MBO_OP_BIT_SET = 4'h8,
    MBO_OP_TEST_SKIP = 4'h9
  } mbo_op_t;
  // execution sequencer, one-hot
  typedef enum logic [3:0] {
    MBO_ST_IDLE = 4'b0001,
    MBO_ST_READ = 4'b0010,
    MBO_ST_EXEC = 4'b0100,
    MBO_ST_SKIP = 4'b1000
  } mbo_state_t;
endpackage

// *** logic/mbo_rfile.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "mbo_defs.svh"
module mbo_rfile
(
  // clock
  input  wire logic       core_clk,
  // write port
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // registered read port
  input  wire logic [6:0] rd_addr,
  output var  logic [7:0] rd_data
);
  logic [7:0] mem [0:`MBO_RF_DEPTH-1];

  // synchronous write
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data from a register
  always_ff @(posedge core_clk)
  begin
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// *** logic/mbo_alu.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "mbo_defs.svh"
module mbo_alu
(
  // operands
  input  wire logic [3:0] op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] lit,
  input  wire logic [7:0] rdat,
  input  wire logic [2:0] bsel,
  // results
  output logic [7:0] res,
  output logic       c_out,
  output logic       dc_out,
  output logic       z_out,
  output logic       bit_val
);
  logic [7:0] b_mask;
  logic [8:0] sum;
  logic [4:0] nsum;
  logic [7:0] opnd;

  // per-bit select mask
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_mask
      assign b_mask[gi] = (bsel == gi[2:0]);
    end
  endgenerate

  // operand choice and adders
  always_comb
  begin
    opnd = (op == mbo_pkg::MBO_OP_ADD_IMM || op == mbo_pkg::MBO_OP_AND_IMM ||
            op == mbo_pkg::MBO_OP_XOR_IMM) ? lit : rdat;
    sum = {1'b0, acc} + {1'b0, opnd};
    nsum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
    bit_val = |(rdat & b_mask);
    case (op)
      mbo_pkg::MBO_OP_ADD_IMM, mbo_pkg::MBO_OP_ADD_REG: res = sum[7:0];
      mbo_pkg::MBO_OP_AND_IMM, mbo_pkg::MBO_OP_AND_REG: res = acc & opnd;
      mbo_pkg::MBO_OP_XOR_IMM, mbo_pkg::MBO_OP_XOR_REG: res = acc ^ opnd;
      mbo_pkg::MBO_OP_BIT_CLR: res = rdat & ~b_mask;
      mbo_pkg::MBO_OP_BIT_SET: res = rdat | b_mask;
      default: res = rdat;
    endcase
    c_out = sum[8];
    dc_out = nsum[4];
    z_out = (res == `MBO_ZERO8);
  end
endmodule
`default_nettype wire

// *** dv/mbo_seq_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module mbo_seq_model
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // skip strobe from the datapath
  input  wire logic       skip_next_r,
  // count of instructions turned into nop
  output var  logic [7:0] drop_cnt_r
);
  // each strobe discards the next fetched instruction
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      drop_cnt_r <= 8'h00;
    else if (skip_next_r)
      drop_cnt_r <= drop_cnt_r + 8'h01;
  end
endmodule
`default_nettype wire

// *** dv/mcu_alu_bit_logic_ops_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "mbo_defs.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module mcu_alu_bit_logic_ops_tb;
  // design pins
  logic        core_clk, nrst, skip_next_r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, drop_cnt;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  // reference state
  int          error_cnt, n_checks;
  logic [7:0]  acc_m;
  logic [7:0]  rf_m [128];
  logic        c_m, dc_m, z_m;

  mbo_top mbo_top_inst (.core_clk(core_clk), .nrst(nrst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .skip_next_r(skip_next_r));

  mbo_seq_model mbo_seq_model_inst (.core_clk(core_clk), .nrst(nrst),
    .skip_next_r(skip_next_r), .drop_cnt_r(drop_cnt));

  // 25 mhz clock
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  // verdict and end of run
  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // a wait that ran out ends the run
  task automatic tmo(input logic ok);
    if (!ok)
    begin
      error_cnt++;
      $display("BAD handshake timeout");
      close_out();
    end
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   i;
    logic aw_t, w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 50 && !(aw_t && w_t); i++)
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_t = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_t = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    tmo(aw_t && w_t);
    for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++)
      @(posedge core_clk);
    tmo(s_axi_bvalid === 1'b1);
    r = s_axi_bresp;
  endtask

  // read: address held until taken, data taken with rvalid
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 50 && !(s_axi_arvalid && s_axi_arready); i++)
      @(posedge core_clk);
    tmo(s_axi_arready === 1'b1);
    s_axi_arvalid <= 1'b0;
    for (i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++)
      @(posedge core_clk);
    tmo(s_axi_rvalid === 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask

  task automatic rd8(input logic [7:0] a, output logic [7:0] v);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    v = d[7:0];
  endtask

  task automatic rf_wr(input logic [6:0] ad, input logic [7:0] val);
    wr(`MBO_ADDR_OPND, {17'h0, ad, 8'h00});
    wr(`MBO_ADDR_RFILE, {24'h0, val});
    rf_m[ad] = val;
  endtask

  task automatic set_acc(input logic [7:0] val);
    wr(`MBO_ADDR_ACC, {24'h0, val});
    acc_m = val;
  endtask

  // predict, launch, wait for idle, then compare flags, acc and the byte
  task automatic do_op(input logic [3:0] op, input logic d, input logic [7:0] lit,
                       input logic [6:0] ad, input logic [2:0] b);
    logic [8:0] s;
    logic [7:0] src, res, v, d0;
    logic       sk, imm;
    int         i;
    imm = (op == mbo_pkg::MBO_OP_ADD_IMM) || (op == mbo_pkg::MBO_OP_AND_IMM)
       || (op == mbo_pkg::MBO_OP_XOR_IMM);
    src = imm ? lit : rf_m[ad];
    sk = 1'b0;
    res = 8'h00;
    d0 = drop_cnt;
    case (op)
      mbo_pkg::MBO_OP_ADD_IMM, mbo_pkg::MBO_OP_ADD_REG:
      begin
        s = {1'b0, acc_m} + {1'b0, src};
        res = s[7:0];
        c_m = s[8];
        dc_m = ({1'b0, acc_m[3:0]} + {1'b0, src[3:0]}) > 5'h0f;
      end
      mbo_pkg::MBO_OP_AND_IMM, mbo_pkg::MBO_OP_AND_REG: res = acc_m & src;
      mbo_pkg::MBO_OP_XOR_IMM, mbo_pkg::MBO_OP_XOR_REG: res = acc_m ^ src;
      mbo_pkg::MBO_OP_BIT_CLR: rf_m[ad][b] = 1'b0;
      mbo_pkg::MBO_OP_BIT_SET: rf_m[ad][b] = 1'b1;
      default: sk = rf_m[ad][b];
    endcase
    if (op >= mbo_pkg::MBO_OP_ADD_IMM && op <= mbo_pkg::MBO_OP_XOR_REG)
    begin
      z_m = (res == 8'h00);
      if (imm || !d)
        acc_m = res;
      else
        rf_m[ad] = res;
    end
    wr(`MBO_ADDR_OPND, {13'h0, b, 1'b0, ad, lit});
    wr(`MBO_ADDR_CTRL, {24'h0, op, 2'b00, d, 1'b1});
    v = 8'h10;
    for (i = 0; i < 20 && v[4] !== 1'b0; i++)
      rd8(`MBO_ADDR_FLAGS, v);
    tmo(v[4] === 1'b0);
    `CHK("flags", {z_m, dc_m, c_m}, v[2:0])
    if (op == mbo_pkg::MBO_OP_TEST_SKIP)
    begin
      `CHK("skip", sk, v[3])
      `CHK("drops", d0 + {7'h0, sk}, drop_cnt)
    end
    rd8(`MBO_ADDR_ACC, v);
    `CHK("acc", acc_m, v)
    wr(`MBO_ADDR_OPND, {17'h0, ad, 8'h00});
    rd8(`MBO_ADDR_RDATA, v);
    `CHK("rfile", rf_m[ad], v)
  endtask

  // logic op table, all on byte 3
  logic [3:0] lop [8] = '{mbo_pkg::MBO_OP_AND_IMM, mbo_pkg::MBO_OP_AND_REG,
    mbo_pkg::MBO_OP_XOR_IMM, mbo_pkg::MBO_OP_XOR_REG, mbo_pkg::MBO_OP_XOR_REG,
    mbo_pkg::MBO_OP_AND_REG, mbo_pkg::MBO_OP_XOR_IMM, mbo_pkg::MBO_OP_AND_IMM};
  logic       ldst [8] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [7:0] llit [8] = '{8'hf0, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hcf, 8'h00};

  // main sequence
  initial
  begin
    logic [7:0]  v;
    logic [31:0] d;
    logic [1:0]  r;
    nrst = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    s_axi_wstrb = 4'hf;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    error_cnt = 0;
    n_checks = 0;
    {c_m, dc_m, z_m} = 3'b000;
    acc_m = 8'h00;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd8(`MBO_ADDR_FLAGS, v);
    `CHK("flags_rst", 8'h00, v)
    // carry, nibble carry and zero all at once
    set_acc(8'h0f);
    do_op(mbo_pkg::MBO_OP_ADD_IMM, 1'b0, 8'hf1, 7'h00, 3'h0);
    rf_wr(7'h03, 8'h5a);
    set_acc(8'h3c);
    for (int i = 0; i < 8; i++)
      do_op(lop[i], ldst[i], llit[i], 7'h03, 3'h0);
    rf_wr(7'h7f, 8'h88);
    set_acc(8'h88);
    do_op(mbo_pkg::MBO_OP_ADD_REG, 1'b1, 8'h00, 7'h7f, 3'h0);
    do_op(mbo_pkg::MBO_OP_ADD_REG, 1'b0, 8'h00, 7'h7f, 3'h0);
    do_op(mbo_pkg::MBO_OP_ADD_IMM, 1'b0, 8'hff, 7'h00, 3'h0);
    rf_wr(7'h05, 8'h00);
    for (int i = 0; i < 8; i++)
      do_op(mbo_pkg::MBO_OP_BIT_SET, 1'b0, 8'h00, 7'h05, 3'(i));
    for (int i = 0; i < 8; i += 2)
      do_op(mbo_pkg::MBO_OP_BIT_CLR, 1'b0, 8'h00, 7'h05, 3'(i));
    for (int i = 0; i < 8; i++)
      do_op(mbo_pkg::MBO_OP_TEST_SKIP, 1'b0, 8'h00, 7'h05, 3'(i));
    // unmapped places answer with an error
    axi_wr(8'h20, 32'h0, r);
    `CHK("bresp", `MBO_AXI_SLVERR, r)
    axi_rd(8'h24, d, r);
    `CHK("rresp", `MBO_AXI_SLVERR, r)
    close_out();
  end
endmodule
`default_nettype wire
